// >>> rtl/mcu_decode_pkg.sv
// Opcode patterns, field positions, flag layout and reset values for the core decoder
// Assumes 16-bit instruction words and a five-bit status flag vector from the datapath
package mcu_decode_pkg;

   // Top nibble of the instruction word
   localparam logic [3:0] OPC_LITERAL     = 4'h0;
   localparam logic [3:0] OPC_BIT_TOGGLE  = 4'h7;
   localparam logic [3:0] OPC_BIT_SET     = 4'h8;
   localparam logic [3:0] OPC_BIT_CLEAR   = 4'h9;
   localparam logic [3:0] OPC_TEST_SET    = 4'hA;
   localparam logic [3:0] OPC_TEST_CLEAR  = 4'hB;
   localparam logic [3:0] OPC_RELATIVE    = 4'hD;
   localparam logic [3:0] OPC_CONTROL     = 4'hE;
   localparam logic [3:0] OPC_SECOND_WORD = 4'hF;

   // Second nibble under the literal prefix
   localparam logic [3:0] LIT_SPECIAL = 4'h0;
   localparam logic [3:0] LIT_BANK    = 4'h1;
   localparam logic [3:0] LIT_RSUB    = 4'h8;
   localparam logic [3:0] LIT_OR      = 4'h9;
   localparam logic [3:0] LIT_XOR     = 4'hA;
   localparam logic [3:0] LIT_AND     = 4'hB;
   localparam logic [3:0] LIT_RETK    = 4'hC;
   localparam logic [3:0] LIT_MUL     = 4'hD;
   localparam logic [3:0] LIT_LOADW   = 4'hE;
   localparam logic [3:0] LIT_ADD     = 4'hF;

   // Second nibble under the control prefix
   localparam logic [3:0] CTL_CALL_A  = 4'hC;
   localparam logic [3:0] CTL_CALL_B  = 4'hD;
   localparam logic [3:0] CTL_POINTER = 4'hE;
   localparam logic [3:0] CTL_JUMP    = 4'hF;

   // Fixed single-word control codes (low byte, upper byte zero)
   localparam logic [7:0] CODE_STANDBY  = 8'h03;
   localparam logic [7:0] CODE_KICK     = 8'h04;
   localparam logic [7:0] CODE_PUSH     = 8'h05;
   localparam logic [7:0] CODE_POP      = 8'h06;
   localparam logic [7:0] CODE_RETI     = 8'h10;
   localparam logic [7:0] CODE_RET      = 8'h12;
   localparam logic [7:0] CODE_RESET    = 8'hFF;
   localparam logic [7:0] CODE_TBL_RD   = 8'h08;
   localparam logic [7:0] CODE_TBL_WR   = 8'h0C;

   // Status flag positions
   localparam int FLAG_C  = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z  = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_N  = 4;
   localparam logic [4:0] MASK_ARITH = 5'h1F;
   localparam logic [4:0] MASK_LOGIC = 5'h14;

   // Branch condition codes
   localparam logic [2:0] COND_ZERO   = 3'h0;
   localparam logic [2:0] COND_NZERO  = 3'h1;
   localparam logic [2:0] COND_CARRY  = 3'h2;
   localparam logic [2:0] COND_NCARRY = 3'h3;
   localparam logic [2:0] COND_OVF    = 3'h4;
   localparam logic [2:0] COND_NOVF   = 3'h5;
   localparam logic [2:0] COND_NEG    = 3'h6;
   localparam logic [2:0] COND_NNEG   = 3'h7;

   // Reset values of the power status bits
   localparam logic WDT_EXPIRED_RESET = 1'b1;
   localparam logic POWERDOWN_RESET   = 1'b1;

   typedef enum logic [2:0] {
      ST_EXEC  = 3'b001,
      ST_WORD2 = 3'b010,
      ST_FLUSH = 3'b100
   } dec_state_t;

   typedef enum logic [4:0] {
      OP_NOP, OP_OTHER, OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_TOGGLE, OP_BIT_TEST,
      OP_BRANCH_COND, OP_JUMP_REL, OP_CALL_REL, OP_JUMP_ABS, OP_CALL_ABS,
      OP_STANDBY, OP_WDT_KICK, OP_PUSH, OP_POP, OP_RET_IRQ, OP_RET, OP_RET_CONST,
      OP_ADD_K, OP_AND_K, OP_OR_K, OP_XOR_K, OP_RSUB_K, OP_LOAD_W, OP_MUL_K,
      OP_LOAD_PTR, OP_SET_BANK, OP_TBL_READ, OP_TBL_WRITE, OP_SOFT_RESET
   } op_t;

endpackage

// >>> rtl/cond_eval.sv
// Branch condition and bit-test skip evaluation
// Assumes status flags and the addressed register value are current in the decode cycle
`timescale 1ns/10ps
`default_nettype none
module cond_eval
   import mcu_decode_pkg::*;
(
   input  wire logic [2:0] cond,
   input  wire logic [4:0] status,
   input  wire logic [2:0] bit_sel,
   input  wire logic [7:0] reg_data,
   input  wire logic       skip_if_set,
   output logic            branch_true,
   output logic            skip_true
);

   always_comb begin
      case (cond)
         COND_ZERO:   branch_true = status[FLAG_Z];
         COND_NZERO:  branch_true = ~status[FLAG_Z];
         COND_CARRY:  branch_true = status[FLAG_C];
         COND_NCARRY: branch_true = ~status[FLAG_C];
         COND_OVF:    branch_true = status[FLAG_OV];
         COND_NOVF:   branch_true = ~status[FLAG_OV];
         COND_NEG:    branch_true = status[FLAG_N];
         COND_NNEG:   branch_true = ~status[FLAG_N];
         default:     branch_true = 1'b0;
      endcase
   end

   // Skip on a set bit or on a clear bit
   assign skip_true = (reg_data[bit_sel] == skip_if_set);

endmodule
`default_nettype wire

// >>> rtl/literal_alu.sv
// Literal arithmetic and logic against the working register, with flag results
// Assumes the op class is already decoded; purely combinational
`timescale 1ns/10ps
`default_nettype none
module literal_alu
   import mcu_decode_pkg::*;
(
   input  wire op_t        op,
   input  wire logic [7:0] w_in,
   input  wire logic [7:0] k_in,
   output logic [7:0]      result,
   output logic [15:0]     product,
   output logic [4:0]      flags,
   output logic [4:0]      mask,
   output logic            w_write
);

   logic [8:0] sum9;
   logic [8:0] diff9;
   logic [4:0] low_sum;
   logic [4:0] low_diff;

   assign sum9     = {1'b0, w_in} + {1'b0, k_in};
   assign diff9    = {1'b0, k_in} - {1'b0, w_in};
   assign low_sum  = {1'b0, w_in[3:0]} + {1'b0, k_in[3:0]};
   assign low_diff = {1'b0, k_in[3:0]} - {1'b0, w_in[3:0]};
   assign product  = {8'h00, w_in} * {8'h00, k_in};

   always_comb begin
      result  = k_in;
      flags   = 5'h00;
      mask    = 5'h00;
      w_write = 1'b0;
      case (op)
         OP_ADD_K: begin
            result        = sum9[7:0];
            flags[FLAG_C] = sum9[8];
            flags[FLAG_DC] = low_sum[4];
            flags[FLAG_OV] = (w_in[7] == k_in[7]) && (sum9[7] != w_in[7]);
            mask          = MASK_ARITH;
            w_write       = 1'b1;
         end
         OP_RSUB_K: begin
            result        = diff9[7:0];
            flags[FLAG_C] = ~diff9[8];
            flags[FLAG_DC] = ~low_diff[4];
            flags[FLAG_OV] = (k_in[7] != w_in[7]) && (diff9[7] != k_in[7]);
            mask          = MASK_ARITH;
            w_write       = 1'b1;
         end
         OP_AND_K: begin
            result  = w_in & k_in;
            mask    = MASK_LOGIC;
            w_write = 1'b1;
         end
         OP_OR_K: begin
            result  = w_in | k_in;
            mask    = MASK_LOGIC;
            w_write = 1'b1;
         end
         OP_XOR_K: begin
            result  = w_in ^ k_in;
            mask    = MASK_LOGIC;
            w_write = 1'b1;
         end
         OP_LOAD_W, OP_RET_CONST: begin
            w_write = 1'b1;
         end
         default: begin
            result = k_in;
         end
      endcase
      flags[FLAG_Z] = (result == 8'h00);
      flags[FLAG_N] = result[7];
   end

endmodule
`default_nettype wire

// >>> rtl/mcu_core_instruction_decoder.sv
// Instruction decoder between the program fetch unit and the core datapath
// Assumes one word per cycle with INSTR_VALID; datapath supplies W, flags and the addressed byte
//
// Behaviour
// - Nibbles 1011/1010 test a register bit; skip next when clear/set respectively
// - 1110 0ccc decodes conditional branch on zero, carry, overflow, negative or inverse
// - Conditional branch: one cycle if false, two if taken; flags untouched
// - Absolute call is two words, 1110 110s then 1111; s selects fast save
// - Absolute jump is two words, 1110 1111 then 1111 with twelve more bits
// - Standby 0x0003 and watchdog kick 0x0004 update expired and powerdown flags
// - Word 0x0006 pops the return stack in one cycle, no flags
// - Word 0x0005 pushes the return stack in one cycle, no flags
// - Interrupt and plain returns take two cycles; interrupt return re-enables interrupts
// - 0000 1100 loads literal into working register and returns, two cycles
// - Literal add, and, or, xor, reverse subtract act on working register in one cycle
// - Add and subtract set all five flags; logic ops set zero and negative only
// - Pointer load is two words giving a twelve-bit value for one of pointers
// - 0000 0001 0000 kkkk writes four bits of bank select in one cycle
// - Nibble 1110 loads literal into working register, one cycle, no flags
// - Nibble 1101 multiplies working register by literal, one cycle, no flags
// - Words 0x0008 to 0x000B read program memory with four pointer modes, two cycles
// - Words 0x000C to 0x000F write program memory with four pointer modes, two cycles
// - A changed program counter or true skip adds a cycle executed as no-op, except after a two-word absolute jump or call
// - Top nibble 1111 executes as no-op unless consumed as a second word
// - Port read-modify-write takes the source value from the pins
// - A write to the timer zero count clears its prescaler when assigned
`timescale 1ns/10ps
`default_nettype none
module mcu_core_instruction_decoder
   import mcu_decode_pkg::*;
#(
   parameter logic [7:0] TIMER_ZERO_ADDR = 8'hE0,
   parameter logic [7:0] PORT_ADDR_FIRST = 8'hC0,
   parameter logic [7:0] PORT_ADDR_LAST  = 8'hC4
)(
   input  wire logic        REF_CLK,
   input  wire logic        NRST,
   input  wire logic        INSTR_VALID,
   input  wire logic [15:0] INSTR_WORD,
   input  wire logic [7:0]  REG_READ_DATA,
   input  wire logic [4:0]  STATUS_IN,
   input  wire logic [7:0]  W_IN,
   input  wire logic        HIGH_IRQ_ACTIVE,
   input  wire logic        PRESCALER_ASSIGNED,
   output var  op_t         OP_CLASS,
   output logic             OP_VALID,
   output logic [15:0]      INSTR_OUT,
   output logic [2:0]       BIT_INDEX,
   output logic             ACCESS_SEL,
   output logic [7:0]       REG_ADDR,
   output logic [7:0]       LITERAL,
   output logic [19:0]      JUMP_TARGET,
   output logic [10:0]      REL_OFFSET,
   output logic             FAST_SEL,
   output logic [1:0]       SUB_MODE,
   output logic [11:0]      POINTER_VALUE,
   output logic             W_WRITE,
   output logic [7:0]       W_RESULT,
   output logic [15:0]      PROD_RESULT,
   output logic [4:0]       FLAG_MASK,
   output logic [4:0]       FLAG_VALUE,
   output logic             FLUSH_NEXT,
   output logic             PIN_SOURCE,
   output logic             PRESCALER_CLEAR,
   output logic [1:0]       IRQ_REENABLE,
   output logic             WDT_EXPIRED_FLAG,
   output logic             POWERDOWN_FLAG
);

   // Register address hit for an access-bank special register range
   function automatic logic reg_hit(input logic [7:0] addr, input logic acc,
                                    input logic [7:0] lo, input logic [7:0] hi);
      reg_hit = !acc && (addr >= lo) && (addr <= hi);
   endfunction

   dec_state_t  state_q;
   logic [15:0] first_q;
   logic [15:0] fw;
   op_t         dec_op;
   logic        dec_two_word;
   logic        dec_flush;
   logic        branch_true;
   logic        skip_true;
   logic [7:0]  alu_result;
   logic [15:0] alu_product;
   logic [4:0]  alu_flags;
   logic [4:0]  alu_mask;
   logic        alu_w_write;
   logic        issue;
   logic        issue_nop;
   logic        flush_d;
   logic        bit_write;

   // Fields come from the held first word while its second word arrives
   assign fw = (state_q == ST_WORD2) ? first_q : INSTR_WORD;

   always_comb begin
      dec_op       = OP_OTHER;
      dec_two_word = 1'b0;
      dec_flush    = 1'b0;
      case (fw[15:12])
         OPC_BIT_CLEAR:  dec_op = OP_BIT_CLEAR;
         OPC_BIT_SET:    dec_op = OP_BIT_SET;
         OPC_BIT_TOGGLE: dec_op = OP_BIT_TOGGLE;
         OPC_TEST_CLEAR, OPC_TEST_SET: dec_op = OP_BIT_TEST;
         OPC_RELATIVE: begin
            dec_op    = fw[11] ? OP_CALL_REL : OP_JUMP_REL;
            dec_flush = 1'b1;
         end
         OPC_CONTROL: begin
            if (!fw[11]) begin
               dec_op = OP_BRANCH_COND;
            end else begin
               case (fw[11:8])
                  CTL_CALL_A, CTL_CALL_B: begin
                     dec_op       = OP_CALL_ABS;
                     dec_two_word = 1'b1;
                  end
                  CTL_JUMP: begin
                     dec_op       = OP_JUMP_ABS;
                     dec_two_word = 1'b1;
                  end
                  CTL_POINTER: begin
                     if (fw[7:6] == 2'b00) begin
                        dec_op       = OP_LOAD_PTR;
                        dec_two_word = 1'b1;
                     end
                  end
                  default: dec_op = OP_OTHER;
               endcase
            end
         end
         OPC_SECOND_WORD: dec_op = OP_NOP;
         OPC_LITERAL: begin
            case (fw[11:8])
               LIT_ADD:   dec_op = OP_ADD_K;
               LIT_AND:   dec_op = OP_AND_K;
               LIT_OR:    dec_op = OP_OR_K;
               LIT_XOR:   dec_op = OP_XOR_K;
               LIT_RSUB:  dec_op = OP_RSUB_K;
               LIT_LOADW: dec_op = OP_LOAD_W;
               LIT_MUL:   dec_op = OP_MUL_K;
               LIT_RETK: begin
                  dec_op    = OP_RET_CONST;
                  dec_flush = 1'b1;
               end
               LIT_BANK: begin
                  if (fw[7:4] == 4'h0) begin
                     dec_op = OP_SET_BANK;
                  end
               end
               LIT_SPECIAL: begin
                  if (fw[7:0] == 8'h00) begin
                     dec_op = OP_NOP;
                  end else if (fw[7:0] == CODE_STANDBY) begin
                     dec_op = OP_STANDBY;
                  end else if (fw[7:0] == CODE_KICK) begin
                     dec_op = OP_WDT_KICK;
                  end else if (fw[7:0] == CODE_PUSH) begin
                     dec_op = OP_PUSH;
                  end else if (fw[7:0] == CODE_POP) begin
                     dec_op = OP_POP;
                  end else if (fw[7:0] == CODE_RESET) begin
                     dec_op = OP_SOFT_RESET;
                  end else if (fw[7:1] == CODE_RETI[7:1]) begin
                     dec_op    = OP_RET_IRQ;
                     dec_flush = 1'b1;
                  end else if (fw[7:1] == CODE_RET[7:1]) begin
                     dec_op    = OP_RET;
                     dec_flush = 1'b1;
                  end else if (fw[7:2] == CODE_TBL_RD[7:2]) begin
                     dec_op    = OP_TBL_READ;
                     dec_flush = 1'b1;
                  end else if (fw[7:2] == CODE_TBL_WR[7:2]) begin
                     dec_op    = OP_TBL_WRITE;
                     dec_flush = 1'b1;
                  end
               end
               default: dec_op = OP_OTHER;
            endcase
         end
         default: dec_op = OP_OTHER;
      endcase
   end

   cond_eval u_cond (
      .cond        (fw[10:8]),
      .status      (STATUS_IN),
      .bit_sel     (fw[11:9]),
      .reg_data    (REG_READ_DATA),
      .skip_if_set (~fw[12]),
      .branch_true (branch_true),
      .skip_true   (skip_true)
   );

   literal_alu u_alu (
      .op      (dec_op),
      .w_in    (W_IN),
      .k_in    (fw[7:0]),
      .result  (alu_result),
      .product (alu_product),
      .flags   (alu_flags),
      .mask    (alu_mask),
      .w_write (alu_w_write)
   );

   assign issue_nop = INSTR_VALID && (state_q == ST_FLUSH);
   assign issue     = INSTR_VALID && ((state_q == ST_WORD2) ||
                      ((state_q == ST_EXEC) && !dec_two_word));
   assign flush_d   = issue && (state_q == ST_EXEC) &&
                      (dec_flush ||
                       ((dec_op == OP_BRANCH_COND) && branch_true) ||
                       ((dec_op == OP_BIT_TEST) && skip_true));
   assign bit_write = (dec_op == OP_BIT_CLEAR) || (dec_op == OP_BIT_SET) ||
                      (dec_op == OP_BIT_TOGGLE);

   // Sequencing: second-word capture and flushed slot
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         state_q <= ST_EXEC;
         first_q <= 16'h0000;
      end else if (INSTR_VALID) begin
         case (state_q)
            ST_EXEC: begin
               if (dec_two_word) begin
                  state_q <= ST_WORD2;
                  first_q <= INSTR_WORD;
               end else if (flush_d) begin
                  state_q <= ST_FLUSH;
               end
            end
            ST_WORD2: state_q <= ST_EXEC;
            ST_FLUSH: state_q <= ST_EXEC;
            default:  state_q <= ST_EXEC;
         endcase
      end
   end

   // Operation class and raw fields
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         OP_VALID      <= 1'b0;
         OP_CLASS      <= OP_NOP;
         INSTR_OUT     <= 16'h0000;
         BIT_INDEX     <= 3'h0;
         ACCESS_SEL    <= 1'b0;
         REG_ADDR      <= 8'h00;
         LITERAL       <= 8'h00;
         JUMP_TARGET   <= 20'h00000;
         REL_OFFSET    <= 11'h000;
         FAST_SEL      <= 1'b0;
         SUB_MODE      <= 2'h0;
         POINTER_VALUE <= 12'h000;
         FLUSH_NEXT    <= 1'b0;
      end else begin
         OP_VALID   <= issue || issue_nop;
         FLUSH_NEXT <= flush_d;
         if (issue_nop) begin
            OP_CLASS <= OP_NOP;
         end else if (issue) begin
            OP_CLASS      <= dec_op;
            INSTR_OUT     <= fw;
            BIT_INDEX     <= fw[11:9];
            ACCESS_SEL    <= fw[8];
            REG_ADDR      <= fw[7:0];
            LITERAL       <= fw[7:0];
            FAST_SEL      <= fw[0];
            SUB_MODE      <= (dec_op == OP_LOAD_PTR) ? fw[5:4] : fw[1:0];
            JUMP_TARGET   <= {INSTR_WORD[11:0], fw[7:0]};
            POINTER_VALUE <= {fw[3:0], INSTR_WORD[7:0]};
            if (dec_op == OP_BRANCH_COND) begin
               REL_OFFSET <= {{3{fw[7]}}, fw[7:0]};
            end else begin
               REL_OFFSET <= fw[10:0];
            end
            if (dec_op == OP_CALL_ABS) begin
               FAST_SEL <= fw[8];
            end
         end
      end
   end

   // Working register and flag results
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         W_WRITE     <= 1'b0;
         W_RESULT    <= 8'h00;
         PROD_RESULT <= 16'h0000;
         FLAG_MASK   <= 5'h00;
         FLAG_VALUE  <= 5'h00;
      end else begin
         W_WRITE   <= issue && alu_w_write;
         FLAG_MASK <= issue ? alu_mask : 5'h00;
         if (issue) begin
            W_RESULT    <= alu_result;
            FLAG_VALUE  <= alu_flags;
            PROD_RESULT <= alu_product;
         end
      end
   end

   // Side effects on ports, timer, interrupt enables
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         PIN_SOURCE      <= 1'b0;
         PRESCALER_CLEAR <= 1'b0;
         IRQ_REENABLE    <= 2'b00;
      end else begin
         PIN_SOURCE      <= issue && bit_write &&
                            reg_hit(fw[7:0], fw[8], PORT_ADDR_FIRST, PORT_ADDR_LAST);
         PRESCALER_CLEAR <= issue && bit_write && PRESCALER_ASSIGNED &&
                            reg_hit(fw[7:0], fw[8], TIMER_ZERO_ADDR, TIMER_ZERO_ADDR);
         if (issue && (dec_op == OP_RET_IRQ)) begin
            IRQ_REENABLE <= HIGH_IRQ_ACTIVE ? 2'b10 : 2'b01;
         end else begin
            IRQ_REENABLE <= 2'b00;
         end
      end
   end

   // Watchdog-expired and powerdown status bits
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         WDT_EXPIRED_FLAG <= WDT_EXPIRED_RESET;
         POWERDOWN_FLAG   <= POWERDOWN_RESET;
      end else if (issue) begin
         if (dec_op == OP_STANDBY) begin
            WDT_EXPIRED_FLAG <= 1'b1;
            POWERDOWN_FLAG   <= 1'b0;
         end else if (dec_op == OP_WDT_KICK) begin
            WDT_EXPIRED_FLAG <= 1'b1;
            POWERDOWN_FLAG   <= 1'b1;
         end else if (dec_op == OP_SOFT_RESET) begin
            WDT_EXPIRED_FLAG <= WDT_EXPIRED_RESET;
            POWERDOWN_FLAG   <= POWERDOWN_RESET;
         end
      end
   end

endmodule
`default_nettype wire

// >>> tb/decoder_monitor.sv
// Port checker for the instruction decoder
// Assumes it is bound onto the decoder top module
`timescale 1ns/10ps
`default_nettype none
module decoder_monitor import mcu_decode_pkg::*; (
   input wire logic       REF_CLK, NRST, OP_VALID, W_WRITE, FLUSH_NEXT, INSTR_VALID,
   input wire logic       HIGH_IRQ_ACTIVE, WDT_EXPIRED_FLAG, POWERDOWN_FLAG,
   input wire op_t        OP_CLASS,
   input wire logic [7:0] W_IN, W_RESULT, LITERAL,
   input wire logic [4:0] FLAG_MASK,
   input wire logic [1:0] IRQ_REENABLE
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   chk_arith_mask: assert property (
      OP_VALID && OP_CLASS inside {OP_ADD_K, OP_RSUB_K} |-> FLAG_MASK == 5'h1F) else $error("mask");
   chk_logic_mask: assert property (
      OP_VALID && OP_CLASS inside {OP_AND_K, OP_OR_K, OP_XOR_K} |-> FLAG_MASK == 5'h14) else $error("mask");
   chk_quiet_mask: assert property (
      OP_VALID && OP_CLASS inside {OP_BRANCH_COND, OP_LOAD_W, OP_MUL_K, OP_PUSH, OP_POP,
      OP_TBL_READ, OP_TBL_WRITE} |-> FLAG_MASK == 5'h00) else $error("mask");
   chk_flush_ops: assert property (
      OP_VALID && OP_CLASS inside {OP_RET, OP_RET_IRQ, OP_RET_CONST, OP_TBL_READ, OP_TBL_WRITE,
      OP_JUMP_REL, OP_CALL_REL} |-> FLUSH_NEXT) else $error("flush");
   chk_flush_nop: assert property (
      FLUSH_NEXT && INSTR_VALID |=> OP_VALID && OP_CLASS == OP_NOP) else $error("nop");
   chk_add_result: assert property (
      OP_VALID && OP_CLASS == OP_ADD_K |-> W_WRITE && W_RESULT == 8'(LITERAL + $past(W_IN)))
      else $error("add");
   chk_standby_pwr: assert property (
      OP_VALID && OP_CLASS == OP_STANDBY |-> ##[0:1] (WDT_EXPIRED_FLAG && !POWERDOWN_FLAG))
      else $error("standby");
   chk_irq_select: assert property (
      OP_VALID && OP_CLASS == OP_RET_IRQ |-> IRQ_REENABLE == ($past(HIGH_IRQ_ACTIVE) ? 2'h2 : 2'h1))
      else $error("irq");
   cover property (OP_VALID && OP_CLASS == OP_JUMP_ABS);
   cover property (FLUSH_NEXT && INSTR_VALID);
   cover property (W_WRITE);
endmodule
bind mcu_core_instruction_decoder decoder_monitor mon (.REF_CLK, .NRST, .OP_VALID, .W_WRITE,
   .FLUSH_NEXT, .INSTR_VALID, .HIGH_IRQ_ACTIVE, .WDT_EXPIRED_FLAG, .POWERDOWN_FLAG, .OP_CLASS,
   .W_IN, .W_RESULT, .LITERAL, .FLAG_MASK, .IRQ_REENABLE);
`default_nettype wire

// >>> tb/w_reg_model.sv
// Datapath partner holding the working register
// Assumes one write pulse per issued operation
`timescale 1ns/10ps
`default_nettype none
module w_reg_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       w_write,
   input  wire logic [7:0] w_result,
   output logic [7:0]      w_q
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) w_q <= 8'h00;
      else if (w_write) w_q <= w_result;
   end
endmodule
`default_nettype wire

// >>> tb/mcu_core_instruction_decoder_bench.sv
// Self-checking bench for the instruction decoder
// Assumes the working register model closes the loop
`timescale 1ns/10ps
`default_nettype none
module mcu_core_instruction_decoder_bench import mcu_decode_pkg::*; ;
   typedef struct {op_t op; logic [8:0] w; logic [15:0] x;} exp_t;
   exp_t q[$], e;
   logic REF_CLK = 0, NRST = 0, INSTR_VALID = 0, HIGH_IRQ_ACTIVE = 0, PRESCALER_ASSIGNED = 0;
   logic OP_VALID, W_WRITE, FLUSH_NEXT, WDT_EXPIRED_FLAG, POWERDOWN_FLAG, t;
   logic FAST_SEL, PIN_SOURCE, PRESCALER_CLEAR, ACCESS_SEL;
   logic [19:0] JUMP_TARGET;
   logic [11:0] POINTER_VALUE;
   logic [10:0] REL_OFFSET;
   logic [2:0] BIT_INDEX;
   logic [15:0] INSTR_WORD = 16'h0000, PROD_RESULT;
   logic [7:0] REG_READ_DATA = 8'h00, W_IN, W_RESULT, LITERAL, REG_ADDR, k, w, r;
   logic [4:0] STATUS_IN = 5'h00, FLAG_MASK;
   logic [1:0] IRQ_REENABLE, SUB_MODE;
   op_t OP_CLASS, o;
   int n_mismatch = 0, num_checks = 0, i, fp[4] = '{FLAG_Z, FLAG_C, FLAG_OV, FLAG_N};
   logic [3:0] ln[5] = '{LIT_ADD, LIT_AND, LIT_OR, LIT_XOR, LIT_RSUB};
   op_t lo[5] = '{OP_ADD_K, OP_AND_K, OP_OR_K, OP_XOR_K, OP_RSUB_K};
   logic [15:0] wd[12] = '{16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0105, 16'h0D21,
      16'hF0F0, 16'h0010, 16'h0013, 16'h0C77, 16'hD123, 16'hD923};
   logic [15:0] xd[12] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0B9A, 16'h0000,
      16'h0000, 16'h0001, 16'h0000, 16'h0123, 16'h0123};
   op_t od[12] = '{OP_STANDBY, OP_WDT_KICK, OP_PUSH, OP_POP, OP_SET_BANK, OP_MUL_K, OP_NOP,
      OP_RET_IRQ, OP_RET, OP_RET_CONST, OP_JUMP_REL, OP_CALL_REL};
   always #2.5 REF_CLK = ~REF_CLK;
   w_reg_model dp (.clk(REF_CLK), .rst_n(NRST), .w_write(W_WRITE), .w_result(W_RESULT), .w_q(W_IN));
   mcu_core_instruction_decoder uut (.REF_CLK, .NRST, .INSTR_VALID, .INSTR_WORD, .REG_READ_DATA,
      .STATUS_IN, .W_IN, .HIGH_IRQ_ACTIVE, .PRESCALER_ASSIGNED, .OP_CLASS, .OP_VALID, .INSTR_OUT(),
      .BIT_INDEX, .ACCESS_SEL, .REG_ADDR, .LITERAL, .JUMP_TARGET, .REL_OFFSET, .FAST_SEL,
      .SUB_MODE, .POINTER_VALUE, .W_WRITE, .W_RESULT, .PROD_RESULT, .FLAG_MASK, .FLAG_VALUE(),
      .FLUSH_NEXT, .PIN_SOURCE, .PRESCALER_CLEAR, .IRQ_REENABLE, .WDT_EXPIRED_FLAG,
      .POWERDOWN_FLAG);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // One word, then an idle cycle if gap is set; OP_OTHER marks a word that issues nothing
   task automatic send(input logic [15:0] word, input op_t op, input logic [8:0] wv,
                       input bit gap, input logic [15:0] x);
      if (op != OP_OTHER) q.push_back('{op, wv, x});
      INSTR_WORD = word;
      INSTR_VALID = 1;
      @(posedge REF_CLK) #1;
      if (gap) begin
         INSTR_VALID = 0;
         @(posedge REF_CLK) #1;
      end
   endtask
   always @(posedge REF_CLK) begin
      if (OP_VALID === 1'b1 && q.size() == 0) chk(16'h0001, 16'h0000);
      if (OP_VALID === 1'b1 && q.size() > 0) begin
         e = q.pop_front();
         chk(16'(OP_CLASS), 16'(e.op));
         if (e.w[8]) chk({7'h00, W_WRITE, W_RESULT}, {7'h01, e.w[7:0]});
         case (e.op)
            OP_JUMP_ABS: chk(JUMP_TARGET[19:4], e.x);
            OP_LOAD_PTR: chk({2'h0, SUB_MODE, POINTER_VALUE}, e.x);
            OP_MUL_K: chk(PROD_RESULT, e.x);
            OP_BRANCH_COND, OP_JUMP_REL, OP_CALL_REL: chk({5'h00, REL_OFFSET}, e.x);
            OP_RET, OP_RET_IRQ: chk({15'h0000, FAST_SEL}, e.x);
            OP_TBL_READ, OP_TBL_WRITE: chk({14'h0000, SUB_MODE}, e.x);
            OP_BIT_SET, OP_BIT_CLEAR, OP_BIT_TOGGLE:
               chk({PIN_SOURCE, PRESCALER_CLEAR, 2'h0, BIT_INDEX, ACCESS_SEL, REG_ADDR}, e.x);
            default: ;
         endcase
      end
   end
   initial begin
      #100000;
      n_mismatch++;
      finish_test();
   end
   initial begin
      i = $urandom(32'hAF5A);
      repeat (6) @(posedge REF_CLK);
      #1 NRST = 1;
      for (i = 0; i < 5; i++) begin
         k = 8'($urandom);
         w = 8'($urandom);
         r = i == 0 ? w + k : i == 1 ? w & k : i == 2 ? w | k : i == 3 ? w ^ k : k - w;
         send({8'h0E, w}, OP_LOAD_W, {1'b1, w}, 1'b1, 16'h0000);
         send({4'h0, ln[i], k}, lo[i], {1'b1, r}, 1'b1, 16'h0000);
      end
      for (i = 0; i < 16; i++) begin
         STATUS_IN = 5'($urandom);
         t = STATUS_IN[fp[i[2:1]]] ^ i[0];
         send({5'b11100, i[2:0], 8'hF5}, OP_BRANCH_COND, 9'h000, 1'b1, 16'h07F5);
         send(16'h0E5A, t ? OP_NOP : OP_LOAD_W, {~t, 8'h5A}, 1'b1, 16'h0000);
         REG_READ_DATA = 8'($urandom);
         t = REG_READ_DATA[i[2:0]] ^ ~i[3];
         send({i[3] ? OPC_TEST_SET : OPC_TEST_CLEAR, i[2:0], 9'h110}, OP_BIT_TEST, 9'h000,
              1'b1, 16'h0000);
         send(16'hEF33, t ? OP_NOP : OP_OTHER, 9'h000, 1'b1, 16'h0000);
         send(16'hF123, t ? OP_NOP : OP_JUMP_ABS, 9'h000, 1'b1, 16'h1233);
      end
      for (i = 0; i < 20; i++) begin
         HIGH_IRQ_ACTIVE = 1'($urandom);
         o = i < 12 ? od[i] : (i < 16 ? OP_TBL_READ : OP_TBL_WRITE);
         send(i < 12 ? wd[i] : 16'(i - 4), o, {o == OP_RET_CONST, 8'h77}, 1'b0,
              i < 12 ? xd[i] : 16'(i[1:0]));
         send(16'h0E5A, i >= 7 ? OP_NOP : OP_LOAD_W, {i < 7, 8'h5A}, 1'b1, 16'h0000);
      end
      send(16'hEE2B, OP_OTHER, 9'h000, 1'b0, 16'h0000);
      send(16'hF0C4, OP_LOAD_PTR, 9'h000, 1'b1, 16'h2BC4);
      PRESCALER_ASSIGNED = 1;
      send(16'h84E0, OP_BIT_SET, 9'h000, 1'b1, 16'h44E0);
      send(16'h92C2, OP_BIT_CLEAR, 9'h000, 1'b1, 16'h82C2);
      send(16'h7FE0, OP_BIT_TOGGLE, 9'h000, 1'b1, 16'h0FE0);
      repeat (3) @(posedge REF_CLK);
      chk(16'(q.size()), 16'h0000);
      finish_test();
   end
endmodule
`default_nettype wire
